// File: src/pfp_top.sv
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Normal mode: protection writes may only enlarge the guarded region.
// - Special mode: any scenario write accepted; size fields still writable only while their disable bit is set.
// - Reset sequence loads protection from the stored byte at 0x3_FF0C.
// - Double-bit fault on that load: enable bit clear, all others set.
// - Program/erase on guarded area refused, violation flag set.
// - Block erase refused when any sector of the block is guarded.
// - Enable clear: disable bits pick open ranges, rest guarded.
// - Enable set: disable bits pick guarded ranges; both set means none.
// - High disable bit 5 governs range ending at 0x3_FFFF; 1 disables.
// - High size field bits 4-3 writable only while high disable set.
// - High size 00/01/10/11 selects 2/4/8/16 Kbytes ending at top.
// - Low disable bit 2 governs range from 0x3_8000; 1 disables.
// - Low size field bits 1-0 writable only while low disable set.
// - Low size 00/01/10/11 selects 1/2/4/8 Kbytes from 0x3_8000.
// - Normal mode: illegal scenario write ignored; reads show active one.
module pfp_top (
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	// Operating mode
	input wire logic I_SPECIAL_MODE,
	// AXI4-Lite write channels
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [pfp_pkg::REG_AW-1:0] I_AWADDR,
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	// AXI4-Lite read channels
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [pfp_pkg::REG_AW-1:0] I_ARADDR,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	// Nonvolatile load during reset sequence
	output logic O_NV_RD_REQ,
	output logic [pfp_pkg::FLASH_AW-1:0] O_NV_RD_ADDR,
	input wire pfp_pkg::pfp_load_type I_NV,
	// Command check
	input wire pfp_pkg::pfp_cmd_type I_CMD,
	output pfp_pkg::pfp_result_type O_CMD_RESULT,
	// Interrupt
	output logic O_IRQ
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] prot_r, prot_nxt;
	logic [pfp_pkg::STAT_W-1:0] status_r, status_nxt;
	logic [pfp_pkg::STAT_W-1:0] mask_r, mask_nxt;
	logic nv_req_r, nv_req_nxt;
	pfp_pkg::pfp_result_type result_r, result_nxt;

	logic aw_hold_r, aw_hold_nxt;
	logic [pfp_pkg::REG_AW-1:0] awaddr_r, awaddr_nxt;
	logic w_hold_r, w_hold_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	logic do_write;
	logic wr_prot;
	logic wr_stat;
	logic wr_mask;
	logic [7:0] cand;
	logic accept;
	logic [7:0] allowed;
	logic addr_protected;
	logic block_protected;
	logic refuse;
	logic [pfp_pkg::STAT_W-1:0] stat_set;
	logic [pfp_pkg::STAT_W-1:0] stat_clr;

	function automatic logic mapped(input logic [pfp_pkg::REG_AW-1:0] a);
		mapped = (a == pfp_pkg::OFS_PROTECT) || (a == pfp_pkg::OFS_STATUS) ||
			(a == pfp_pkg::OFS_MASK) || (a == pfp_pkg::OFS_INFO);
	endfunction

	// ----------------------------------------
	// Range decision
	// ----------------------------------------
	pfp_range_check u_range (
		.i_prot(prot_r),
		.i_addr(I_CMD.addr),
		.o_addr_protected(addr_protected),
		.o_block_protected(block_protected)
	);

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign O_AWREADY = !aw_hold_r && !bvalid_r;
	assign O_WREADY = !w_hold_r && !bvalid_r;
	assign O_ARREADY = !rvalid_r;
	assign O_BVALID = bvalid_r;
	assign O_BRESP = bresp_r;
	assign O_RVALID = rvalid_r;
	assign O_RDATA = rdata_r;
	assign O_RRESP = rresp_r;
	assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_prot = do_write && wstrb_r[0] && (awaddr_r == pfp_pkg::OFS_PROTECT);
	assign wr_stat = do_write && wstrb_r[0] && (awaddr_r == pfp_pkg::OFS_STATUS);
	assign wr_mask = do_write && wstrb_r[0] && (awaddr_r == pfp_pkg::OFS_MASK);

	always_comb begin
		aw_hold_nxt = aw_hold_r;
		awaddr_nxt = awaddr_r;
		w_hold_nxt = w_hold_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (I_AWVALID && O_AWREADY) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt = I_AWADDR;
		end
		if (I_WVALID && O_WREADY) begin
			w_hold_nxt = 1'b1;
			wdata_nxt = I_WDATA;
			wstrb_nxt = I_WSTRB;
		end
		if (do_write) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = mapped(awaddr_r) ? pfp_pkg::RESP_OKAY : pfp_pkg::RESP_SLVERR;
		end else if (bvalid_r && I_BREADY) begin
			bvalid_nxt = 1'b0;
		end
		if (I_ARVALID && O_ARREADY) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = mapped(I_ARADDR) ? pfp_pkg::RESP_OKAY : pfp_pkg::RESP_SLVERR;
			unique case (I_ARADDR)
				// Always the active scenario, never a refused write
				pfp_pkg::OFS_PROTECT: rdata_nxt = {24'h000000, prot_r};
				pfp_pkg::OFS_STATUS: rdata_nxt = {29'h00000000, status_r};
				pfp_pkg::OFS_MASK: rdata_nxt = {29'h00000000, mask_r};
				pfp_pkg::OFS_INFO: rdata_nxt = {27'h0000000, I_SPECIAL_MODE, nv_req_r,
					pfp_pkg::scenario(prot_r)};
				default: rdata_nxt = 32'h00000000;
			endcase
		end else if (rvalid_r && I_RREADY) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			aw_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			w_hold_r <= 1'b0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= pfp_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= pfp_pkg::RESP_OKAY;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			awaddr_r <= awaddr_nxt;
			w_hold_r <= w_hold_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// ----------------------------------------
	// Protection register
	// ----------------------------------------
	always_comb begin
		cand = prot_r;
		cand[pfp_pkg::POPEN_BIT] = wdata_r[pfp_pkg::POPEN_BIT];
		cand[pfp_pkg::HDIS_BIT] = wdata_r[pfp_pkg::HDIS_BIT];
		cand[pfp_pkg::LDIS_BIT] = wdata_r[pfp_pkg::LDIS_BIT];
		// Size fields follow the disable bit as it stands before the write
		if (prot_r[pfp_pkg::HDIS_BIT]) begin
			cand[pfp_pkg::HS_LSB +: 2] = wdata_r[pfp_pkg::HS_LSB +: 2];
		end
		if (prot_r[pfp_pkg::LDIS_BIT]) begin
			cand[pfp_pkg::LS_LSB +: 2] = wdata_r[pfp_pkg::LS_LSB +: 2];
		end
		allowed = pfp_pkg::allowed_row(pfp_pkg::scenario(prot_r));
		// Mode sampled on the very write being applied
		if (I_SPECIAL_MODE) begin
			accept = 1'b1;
		end else begin
			accept = allowed[pfp_pkg::scenario(cand)];
		end
		prot_nxt = prot_r;
		nv_req_nxt = nv_req_r;
		if (I_NV.valid) begin
			// Stored byte takes priority over a bus write in the same cycle
			nv_req_nxt = 1'b0;
			prot_nxt = I_NV.dbl_fault ? pfp_pkg::PROTECT_DBL_FAULT : I_NV.data;
		end else if (wr_prot && accept) begin
			prot_nxt = cand;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			prot_r <= pfp_pkg::PROTECT_RST;
			nv_req_r <= 1'b1;
		end else begin
			prot_r <= prot_nxt;
			nv_req_r <= nv_req_nxt;
		end
	end

	assign O_NV_RD_REQ = nv_req_r;
	assign O_NV_RD_ADDR = pfp_pkg::STORE_ADDR;

	// ----------------------------------------
	// Command check, status and interrupt
	// ----------------------------------------
	always_comb begin
		refuse = I_CMD.erase_block ? block_protected : addr_protected;
		result_nxt.done = I_CMD.valid;
		result_nxt.refused = I_CMD.valid && refuse;
		result_nxt.violation = I_CMD.valid && refuse;
		stat_set = '0;
		stat_set[pfp_pkg::ST_VIOL] = I_CMD.valid && refuse;
		stat_set[pfp_pkg::ST_BLK] = I_CMD.valid && I_CMD.erase_block && block_protected;
		stat_set[pfp_pkg::ST_DBL] = I_NV.valid && I_NV.dbl_fault;
		stat_clr = wr_stat ? wdata_r[pfp_pkg::STAT_W-1:0] : '0;
		// A new event beats a clear in the same cycle
		status_nxt = stat_set | (status_r & ~stat_clr);
		mask_nxt = wr_mask ? wdata_r[pfp_pkg::STAT_W-1:0] : mask_r;
	end

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			result_r <= '0;
			status_r <= pfp_pkg::STATUS_RST;
			mask_r <= pfp_pkg::MASK_RST;
		end else begin
			result_r <= result_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
		end
	end

	assign O_CMD_RESULT = result_r;
	assign O_IRQ = |(status_r & mask_r);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RESETN);

	nv_copy_a: assert property (I_NV.valid && !I_NV.dbl_fault |=> prot_r == $past(I_NV.data))
		else $error("stored byte not loaded");
	dbl_fault_a: assert property (I_NV.valid && I_NV.dbl_fault
		|=> prot_r == 8'h7f && status_r[pfp_pkg::ST_DBL])
		else $error("double fault load not fully protecting");
	high_size_a: assert property (wr_prot && !I_NV.valid && !prot_r[pfp_pkg::HDIS_BIT]
		|=> $stable(prot_r[4:3]))
		else $error("high size changed while range active");
	low_size_a: assert property (wr_prot && !I_NV.valid && !prot_r[pfp_pkg::LDIS_BIT]
		|=> $stable(prot_r[1:0]))
		else $error("low size changed while range active");
	only_adds_a: assert property (wr_prot && !I_NV.valid && !I_SPECIAL_MODE
		|=> |(pfp_pkg::allowed_row(pfp_pkg::scenario($past(prot_r)))
		& (8'h01 << pfp_pkg::scenario(prot_r))))
		else $error("normal mode write reduced protection");
	free_write_a: assert property (wr_prot && !I_NV.valid && I_SPECIAL_MODE
		|=> prot_r[7] == $past(wdata_r[7]) && prot_r[5] == $past(wdata_r[5]))
		else $error("special mode write not applied");
	violation_a: assert property (I_CMD.valid && !I_CMD.erase_block && addr_protected
		|=> O_CMD_RESULT.refused && status_r[pfp_pkg::ST_VIOL])
		else $error("guarded program not refused");
	blk_erase_a: assert property (I_CMD.valid && I_CMD.erase_block && block_protected
		|=> O_CMD_RESULT.refused && status_r[pfp_pkg::ST_BLK])
		else $error("block erase allowed over guarded sector");
	full_guard_a: assert property (I_CMD.valid && !prot_r[7] && prot_r[5] && prot_r[2]
		|=> O_CMD_RESULT.refused)
		else $error("full protection let a command through");
	no_guard_a: assert property (I_CMD.valid && prot_r[7] && prot_r[5] && prot_r[2]
		|=> O_CMD_RESULT.done && !O_CMD_RESULT.refused)
		else $error("command refused with protection off");
	high_top_a: assert property (I_CMD.valid && !I_CMD.erase_block && prot_r[7]
		&& !prot_r[5] && prot_r[2] && I_CMD.addr == 18'h3f800 && prot_r[4:3] == 2'h0
		|=> O_CMD_RESULT.refused)
		else $error("high range bottom not guarded");
	low_base_a: assert property (I_CMD.valid && !I_CMD.erase_block && prot_r[7]
		&& prot_r[5] && !prot_r[2] && I_CMD.addr == 18'h38400 && prot_r[1:0] == 2'h0
		|=> !O_CMD_RESULT.refused)
		else $error("low range overran its size");

endmodule

// File: src/pfp_pkg.sv
package pfp_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam int REG_AW = 8;
	localparam logic [7:0] OFS_PROTECT = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_INFO = 8'h0c;

	// ----------------------------------------
	// Protection register fields
	// ----------------------------------------
	localparam int POPEN_BIT = 7;
	localparam int RNV_BIT = 6;
	localparam int HDIS_BIT = 5;
	localparam int HS_LSB = 3;
	localparam int LDIS_BIT = 2;
	localparam int LS_LSB = 0;
	localparam logic [7:0] PROTECT_RST = 8'h7f;
	localparam logic [7:0] PROTECT_DBL_FAULT = 8'h7f;

	// ----------------------------------------
	// Status / mask bits
	// ----------------------------------------
	localparam int STAT_W = 3;
	localparam int ST_VIOL = 0;
	localparam int ST_BLK = 1;
	localparam int ST_DBL = 2;
	localparam logic [STAT_W-1:0] STATUS_RST = 3'h0;
	localparam logic [STAT_W-1:0] MASK_RST = 3'h0;

	// ----------------------------------------
	// Flash address map
	// ----------------------------------------
	localparam int FLASH_AW = 18;
	localparam logic [FLASH_AW-1:0] STORE_ADDR = 18'h3ff0c;
	localparam logic [FLASH_AW-1:0] FLASH_TOP = 18'h3ffff;
	localparam logic [FLASH_AW-1:0] LOW_BASE = 18'h38000;
	localparam logic [FLASH_AW-1:0] HIGH_MIN_SIZE = 18'h00800;
	localparam logic [FLASH_AW-1:0] LOW_MIN_SIZE = 18'h00400;

	// ----------------------------------------
	// Bus answers
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic dbl_fault;
		logic [7:0] data;
	} pfp_load_type;

	typedef struct packed {
		logic valid;
		logic erase_block;
		logic [FLASH_AW-1:0] addr;
	} pfp_cmd_type;

	typedef struct packed {
		logic done;
		logic refused;
		logic violation;
	} pfp_result_type;

	// Scenario index: operation enable, high disable, low disable
	function automatic logic [2:0] scenario(input logic [7:0] prot);
		scenario = {prot[POPEN_BIT], prot[HDIS_BIT], prot[LDIS_BIT]};
	endfunction

	// Row of legal target scenarios, one bit per target
	function automatic logic [7:0] allowed_row(input logic [2:0] from);
		unique case (from)
			3'h0: allowed_row = 8'h0f;
			3'h1: allowed_row = 8'h0a;
			3'h2: allowed_row = 8'h0c;
			3'h3: allowed_row = 8'h08;
			3'h4: allowed_row = 8'h18;
			3'h5: allowed_row = 8'h3c;
			3'h6: allowed_row = 8'h5a;
			3'h7: allowed_row = 8'hff;
		endcase
	endfunction

endpackage

// File: src/pfp_range_check.sv
`timescale 1ns/1ps
module pfp_range_check (
	// Protection setting
	input wire logic [7:0] i_prot,
	// Target address
	input wire logic [pfp_pkg::FLASH_AW-1:0] i_addr,
	// Decision
	output logic o_addr_protected,
	output logic o_block_protected
);
	logic [pfp_pkg::FLASH_AW-1:0] high_size;
	logic [pfp_pkg::FLASH_AW-1:0] low_size;
	logic in_high;
	logic in_low;
	logic range_hit;
	logic high_on;
	logic low_on;

	always_comb begin
		high_size = pfp_pkg::HIGH_MIN_SIZE << i_prot[pfp_pkg::HS_LSB +: 2];
		low_size = pfp_pkg::LOW_MIN_SIZE << i_prot[pfp_pkg::LS_LSB +: 2];
		high_on = !i_prot[pfp_pkg::HDIS_BIT];
		low_on = !i_prot[pfp_pkg::LDIS_BIT];
		in_high = i_addr > (pfp_pkg::FLASH_TOP - high_size);
		in_low = (i_addr >= pfp_pkg::LOW_BASE) && (i_addr < (pfp_pkg::LOW_BASE + low_size));
		range_hit = (high_on && in_high) || (low_on && in_low);
		if (i_prot[pfp_pkg::POPEN_BIT]) begin
			// Ranges name what is protected
			o_addr_protected = range_hit;
			o_block_protected = high_on || low_on;
		end else begin
			// Ranges name what is left open; the rest is guarded
			o_addr_protected = !range_hit;
			// Largest open ranges never cover the whole block
			o_block_protected = 1'b1;
		end
	end
endmodule

// File: test/pfp_nv_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Stored protection byte source
// ----------------------------------------
module pfp_nv_model #(
	parameter logic [3:0] DELAY = 4'h5
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Load request
	input wire logic i_req,
	input wire logic [pfp_pkg::FLASH_AW-1:0] i_addr,
	// Stored contents
	input wire logic [7:0] i_byte,
	input wire logic i_fault,
	// Load answer
	output pfp_pkg::pfp_load_type o_nv
);
	logic [3:0] wait_r;
	logic fire;

	// Only the configuration byte address is answered, else the load never ends
	assign fire = i_req && (i_addr == pfp_pkg::STORE_ADDR) && (wait_r == DELAY - 4'h1);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wait_r <= 4'h0;
			o_nv <= '0;
		end else begin
			if (i_req && wait_r != DELAY) begin
				wait_r <= wait_r + 4'h1;
			end
			o_nv.valid <= fire;
			// Released lines show the inverse, never a stale copy
			o_nv.data <= fire ? i_byte : ~i_byte;
			o_nv.dbl_fault <= fire ? i_fault : ~i_fault;
		end
	end
endmodule

// File: test/program_flash_protection_register_test.sv
`timescale 1ns/1ps
module program_flash_protection_register_test;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic special = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic [7:0] nv_byte = 8'hff;
	logic nv_fault = 1'b0;
	pfp_pkg::pfp_cmd_type cmd = '0;
	wire awready, wready, bvalid, arready, rvalid, nv_req, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [17:0] nv_addr;
	pfp_pkg::pfp_load_type nv;
	pfp_pkg::pfp_result_type res;
	int error_cnt = 0;
	int total_checks = 0;
	logic [17:0] sz;

	always #50 clk = ~clk;

	pfp_top dut_u (.I_REF_CLK(clk), .I_RESETN(resetn), .I_SPECIAL_MODE(special),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr), .I_WVALID(wvalid),
		.O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BVALID(bvalid),
		.I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata),
		.O_RRESP(rresp), .O_NV_RD_REQ(nv_req), .O_NV_RD_ADDR(nv_addr), .I_NV(nv),
		.I_CMD(cmd), .O_CMD_RESULT(res), .O_IRQ(irq));

	pfp_nv_model nv_u (.i_clk(clk), .i_resetn(resetn), .i_req(nv_req), .i_addr(nv_addr),
		.i_byte(nv_byte), .i_fault(nv_fault), .o_nv(nv));

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw, ta, tw;
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(negedge clk);
			ta = pa && awready;
			tw = pw && wready;
			@(posedge clk);
			if (ta) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		@(negedge clk);
		while (bvalid !== 1'b1) @(negedge clk);
		chk({30'h0, bresp}, {30'h0, er}, "write response");
		@(posedge clk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ta;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		ta = 1'b0;
		while (!ta) begin
			@(negedge clk);
			ta = arready;
			@(posedge clk);
		end
		arvalid <= 1'b0;
		@(negedge clk);
		while (rvalid !== 1'b1) @(negedge clk);
		chk(rdata, e, "read data");
		chk({30'h0, rresp}, {30'h0, er}, "read response");
		@(posedge clk);
		rready <= 1'b0;
	endtask

	task automatic prot(input logic [7:0] d);
		wr(pfp_pkg::OFS_PROTECT, {24'h0, d}, pfp_pkg::RESP_OKAY);
	endtask

	task automatic rdp(input logic [7:0] e);
		rd(pfp_pkg::OFS_PROTECT, {24'h0, e}, pfp_pkg::RESP_OKAY);
	endtask

	// One command, result pulse looked at in its only cycle
	task automatic cmdc(input logic [17:0] a, input logic blk, input logic e);
		@(posedge clk);
		cmd <= '{valid: 1'b1, erase_block: blk, addr: a};
		@(posedge clk);
		cmd.valid <= 1'b0;
		@(negedge clk);
		chk({29'h0, res}, {29'h0, 1'b1, e, e}, "command result");
	endtask

	task automatic irqchk(input logic e);
		@(negedge clk);
		chk({31'h0, irq}, {31'h0, e}, "interrupt level");
	endtask

	task automatic do_reset(input logic f);
		@(posedge clk);
		resetn <= 1'b0;
		nv_fault <= f;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk({31'h0, nv_req}, 32'h1, "load request");
		while (nv_req !== 1'b0) @(negedge clk);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		// Erased stored byte: bit 6 left at one
		do_reset(1'b0);
		chk({14'h0, nv_addr}, {14'h0, pfp_pkg::STORE_ADDR}, "load address");
		rdp(8'hff);
		cmdc(pfp_pkg::LOW_BASE, 1'b1, 1'b0);
		$display("test load done");
		@(posedge clk);
		special <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			sz = pfp_pkg::LOW_MIN_SIZE << k;
			prot(8'ha4 | 8'(k));
			prot(8'ha0 | 8'(k));
			rdp(8'he0 | 8'(k));
			cmdc(pfp_pkg::LOW_BASE + sz - 18'h1, 1'b0, 1'b1);
			cmdc(pfp_pkg::LOW_BASE + sz, 1'b0, 1'b0);
		end
		for (int k = 0; k < 4; k++) begin
			sz = pfp_pkg::HIGH_MIN_SIZE << k;
			prot(8'ha4 | 8'(k << 3));
			prot(8'h84 | 8'(k << 3));
			rdp(8'hc4 | 8'(k << 3));
			cmdc(pfp_pkg::FLASH_TOP - sz + 18'h1, 1'b0, 1'b1);
			cmdc(pfp_pkg::FLASH_TOP - sz, 1'b0, 1'b0);
		end
		cmdc(pfp_pkg::LOW_BASE, 1'b0, 1'b0);
		cmdc(pfp_pkg::LOW_BASE, 1'b1, 1'b1);
		$display("test ranges done");
		// Size field held while its disable bit was clear
		prot(8'h1c);
		rdp(8'h5c);
		cmdc(18'h3c000, 1'b0, 1'b0);
		cmdc(18'h3bfff, 1'b0, 1'b1);
		cmdc(pfp_pkg::LOW_BASE, 1'b1, 1'b1);
		@(posedge clk);
		special <= 1'b0;
		prot(8'hff);
		rdp(8'h5c);
		prot(8'h24);
		rdp(8'h7c);
		cmdc(18'h3c000, 1'b0, 1'b1);
		$display("test modes done");
		rd(pfp_pkg::OFS_STATUS, 32'h3, pfp_pkg::RESP_OKAY);
		irqchk(1'b0);
		wr(pfp_pkg::OFS_MASK, 32'h1, pfp_pkg::RESP_OKAY);
		irqchk(1'b1);
		wr(pfp_pkg::OFS_STATUS, 32'h3, pfp_pkg::RESP_OKAY);
		rd(pfp_pkg::OFS_STATUS, 32'h0, pfp_pkg::RESP_OKAY);
		irqchk(1'b0);
		rd(8'h10, 32'h0, pfp_pkg::RESP_SLVERR);
		rd(pfp_pkg::OFS_INFO, 32'h3, pfp_pkg::RESP_OKAY);
		wr(8'h10, 32'h0, pfp_pkg::RESP_SLVERR);
		$display("test status done");
		// Upper sector opened before the stored byte is changed
		@(posedge clk);
		special <= 1'b1;
		prot(8'hff);
		rd(pfp_pkg::OFS_INFO, 32'h17, pfp_pkg::RESP_OKAY);
		cmdc(pfp_pkg::STORE_ADDR, 1'b0, 1'b0);
		// Second reset in mid-run, load reports a double fault
		nv_byte <= 8'h00;
		do_reset(1'b1);
		rdp(8'h7f);
		rd(pfp_pkg::OFS_STATUS, 32'h4, pfp_pkg::RESP_OKAY);
		cmdc(pfp_pkg::FLASH_TOP, 1'b0, 1'b1);
		wr(pfp_pkg::OFS_MASK, 32'h4, pfp_pkg::RESP_OKAY);
		irqchk(1'b1);
		$display("test fault done");
		end_of_test();
	end

	// Whole run takes under 300 cycles
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
endmodule
